// ### rtl/rimrb_register_bank.sv
module rimrb_register_bank
    import rimrb_pkg::*;
(
    // clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_in,
    // modbus access port
    input  wire logic                    req_valid_in,
    input  wire rimrb_req_t              req_in,
    output logic                         rsp_valid_out,
    output rimrb_rsp_t                   rsp_out,
    // field side
    input  wire logic [NUM_DI-1:0]       di_level_in,
    input  wire rimrb_ai_t [NUM_AI-1:0]  ai_in,
    input  wire logic [NUM_SAFE-1:0]     safe_set_in,
    output logic [NUM_AI-1:0][15:0]      range_mode_out,
    output logic [NUM_SAFE-1:0]          safe_flag_out
);

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] base,
                                 input int          len);
        logic [16:0] lim;
        lim = {1'b0, base} + 17'(len);
        return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < lim);
    endfunction : hit

    function automatic logic [15:0] half(input logic [31:0] v,
                                         input logic        low);
        return low ? v[15:0] : v[31:16];
    endfunction : half

    function automatic logic range_ok(input logic [15:0] code);
        return code == RANGE_0_10V || code == RANGE_4_20MA ||
               code == RANGE_0_20MA || code == RANGE_4_20MA_BURN;
    endfunction : range_ok

    // state
    logic [NUM_DI-1:0]       di_prev_reg;
    logic [NUM_DI-1:0]       run_reg;
    logic [NUM_DI-1:0]       ovf_reg;
    logic [NUM_DI-1:0][31:0] count_reg;
    logic [NUM_SAFE-1:0]     safe_reg;
    logic [NUM_AI-1:0][15:0] range_reg;
    logic [NUM_AI-1:0][31:0] subst_reg;
    logic [NUM_AI-1:0][15:0] raw_reg;
    logic [NUM_AI-1:0][31:0] scaled_reg;
    logic [NUM_AI-1:0][15:0] cond_reg;
    logic [NUM_AI-1:0][15:0] raw_min_reg;
    logic [NUM_AI-1:0][15:0] raw_max_reg;
    logic [NUM_AI-1:0][31:0] scl_min_reg;
    logic [NUM_AI-1:0][31:0] scl_max_reg;
    rimrb_rsp_t              rsp_next;

    // write strobes from decode
    logic [NUM_DI-1:0]       run_wr;
    logic [NUM_DI-1:0]       cnt_rst;
    logic [NUM_DI-1:0]       ovf_clr;
    logic [NUM_SAFE-1:0]     safe_clr;
    logic [NUM_AI-1:0]       min_rst;
    logic [NUM_AI-1:0]       max_rst;
    logic [NUM_AI-1:0]       range_wr;
    logic [NUM_AI-1:0]       subst_hi_wr;
    logic [NUM_AI-1:0]       subst_lo_wr;

    logic [NUM_AI-1:0][31:0] scaled_rep;
    logic [15:0]             ad;
    logic [15:0]             off;
    logic                    wr;
    logic                    bit1;

    // burnout substitution of the reported scaled value
    always_comb begin
        for (int c = 0; c < NUM_AI; c++) begin
            scaled_rep[c] = (cond_reg[c] == COND_BURNOUT) ?
                            subst_reg[c] : scaled_reg[c];
        end
    end

    // address decode, read data and write strobes
    always_comb begin
        rsp_next    = '0;
        run_wr      = '0;
        cnt_rst     = '0;
        ovf_clr     = '0;
        safe_clr    = '0;
        min_rst     = '0;
        max_rst     = '0;
        range_wr    = '0;
        subst_hi_wr = '0;
        subst_lo_wr = '0;
        off         = '0;
        ad          = req_in.addr;
        wr          = req_valid_in && req_in.write;
        bit1        = req_in.wdata[0];
        case (req_in.space)
            SPACE_COIL: begin
                if (hit(ad, ADDR_COUNTER_RUN_CONTROL, NUM_DI)) begin
                    off = ad - ADDR_COUNTER_RUN_CONTROL;
                    rsp_next.rdata = {15'h0, run_reg[off[2:0]]};
                    run_wr[off[2:0]] = wr;
                end else if (hit(ad, ADDR_COUNTER_RESET_COIL, NUM_DI)) begin
                    off = ad - ADDR_COUNTER_RESET_COIL;
                    cnt_rst[off[2:0]] = wr && bit1;
                end else if (hit(ad, ADDR_COUNTER_OVF_CLEAR, NUM_DI)) begin
                    off = ad - ADDR_COUNTER_OVF_CLEAR;
                    ovf_clr[off[2:0]] = wr && bit1;
                end else if (hit(ad, ADDR_OUTPUT_SAFE_CLEAR, NUM_SAFE)) begin
                    off = ad - ADDR_OUTPUT_SAFE_CLEAR;
                    safe_clr[off[1:0]] = wr && bit1;
                end else if (hit(ad, ADDR_ANALOG_MIN_RESET, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_MIN_RESET;
                    min_rst[off[1:0]] = wr && bit1;
                end else if (hit(ad, ADDR_ANALOG_MAX_RESET, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_MAX_RESET;
                    max_rst[off[1:0]] = wr && bit1;
                end else begin
                    rsp_next.err = 1'b1;
                end
            end
            SPACE_DISCRETE: begin
                if (req_in.write) begin
                    rsp_next.err = 1'b1;
                end else if (hit(ad, ADDR_INPUT_LEVEL_BITS, NUM_DI)) begin
                    off = ad - ADDR_INPUT_LEVEL_BITS;
                    rsp_next.rdata = {15'h0, di_prev_reg[off[2:0]]};
                end else if (hit(ad, ADDR_COUNTER_OVERFLOW, NUM_DI)) begin
                    off = ad - ADDR_COUNTER_OVERFLOW;
                    rsp_next.rdata = {15'h0, ovf_reg[off[2:0]]};
                end else if (hit(ad, ADDR_SAFE_FLAG, NUM_SAFE)) begin
                    off = ad - ADDR_SAFE_FLAG;
                    rsp_next.rdata = {15'h0, safe_reg[off[1:0]]};
                end else begin
                    rsp_next.err = 1'b1;
                end
            end
            SPACE_HOLDING: begin
                if (hit(ad, ADDR_ANALOG_RANGE_SELECT, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_RANGE_SELECT;
                    if (req_in.write && !range_ok(req_in.wdata)) begin
                        rsp_next.err = 1'b1;
                    end else begin
                        rsp_next.rdata = range_reg[off[1:0]];
                        range_wr[off[1:0]] = wr;
                    end
                end else if (hit(ad, ADDR_ANALOG_FAULT_SUBST,
                                 2 * NUM_AI)) begin
                    off = ad - ADDR_ANALOG_FAULT_SUBST;
                    rsp_next.rdata = half(subst_reg[off[2:1]], off[0]);
                    subst_hi_wr[off[2:1]] = wr && !off[0];
                    subst_lo_wr[off[2:1]] = wr && off[0];
                end else begin
                    rsp_next.err = 1'b1;
                end
            end
            default: begin
                if (req_in.write) begin
                    rsp_next.err = 1'b1;
                end else if (hit(ad, ADDR_INPUT_COUNTER_VALUE,
                                 2 * NUM_DI)) begin
                    off = ad - ADDR_INPUT_COUNTER_VALUE;
                    rsp_next.rdata = half(count_reg[off[3:1]], off[0]);
                end else if (ad == ADDR_PACKED_INPUT_LEVELS) begin
                    rsp_next.rdata = {8'h00, di_prev_reg};
                end else if (hit(ad, ADDR_ANALOG_RAW_VALUE, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_RAW_VALUE;
                    rsp_next.rdata = raw_reg[off[1:0]];
                end else if (hit(ad, ADDR_ANALOG_SCALED_VALUE,
                                 2 * NUM_AI)) begin
                    off = ad - ADDR_ANALOG_SCALED_VALUE;
                    rsp_next.rdata = half(scaled_rep[off[2:1]], off[0]);
                end else if (hit(ad, ADDR_ANALOG_RAW_MINIMUM, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_RAW_MINIMUM;
                    rsp_next.rdata = raw_min_reg[off[1:0]];
                end else if (hit(ad, ADDR_ANALOG_RAW_MAXIMUM, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_RAW_MAXIMUM;
                    rsp_next.rdata = raw_max_reg[off[1:0]];
                end else if (hit(ad, ADDR_ANALOG_SCALED_MIN,
                                 2 * NUM_AI)) begin
                    off = ad - ADDR_ANALOG_SCALED_MIN;
                    rsp_next.rdata = half(scl_min_reg[off[2:1]], off[0]);
                end else if (hit(ad, ADDR_ANALOG_SCALED_MAX,
                                 2 * NUM_AI)) begin
                    off = ad - ADDR_ANALOG_SCALED_MAX;
                    rsp_next.rdata = half(scl_max_reg[off[2:1]], off[0]);
                end else if (hit(ad, ADDR_ANALOG_CONDITION, NUM_AI)) begin
                    off = ad - ADDR_ANALOG_CONDITION;
                    rsp_next.rdata = cond_reg[off[1:0]];
                end else begin
                    rsp_next.err = 1'b1;
                end
            end
        endcase
        if (!req_valid_in) begin
            rsp_next = '0;
        end
    end

    // answer one cycle after the request
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_out       <= '0;
        end else begin
            rsp_valid_out <= req_valid_in;
            rsp_out       <= rsp_next;
        end
    end

    // digital input sampling
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            di_prev_reg <= '0;
        end else begin
            di_prev_reg <= di_level_in;
        end
    end

    // counter run control
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_DI; i++) begin
                if (run_wr[i]) begin
                    run_reg[i] <= req_in.wdata[0];
                end
            end
        end
    end

    // rising-edge counters and overflow flags
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '{default: RST_COUNTER};
            ovf_reg   <= '0;
        end else begin
            for (int i = 0; i < NUM_DI; i++) begin
                if (cnt_rst[i]) begin
                    count_reg[i] <= RST_COUNTER;
                end else if (run_reg[i] && di_level_in[i] &&
                             !di_prev_reg[i]) begin
                    count_reg[i] <= count_reg[i] + 32'h1;
                end
                // set wins over clear
                if (!cnt_rst[i] && run_reg[i] && di_level_in[i] &&
                    !di_prev_reg[i] && (&count_reg[i])) begin
                    ovf_reg[i] <= 1'b1;
                end else if (ovf_clr[i]) begin
                    ovf_reg[i] <= 1'b0;
                end
            end
        end
    end

    // peer safe-mode flags, set wins over clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            safe_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_SAFE; i++) begin
                if (safe_set_in[i]) begin
                    safe_reg[i] <= 1'b1;
                end else if (safe_clr[i]) begin
                    safe_reg[i] <= 1'b0;
                end
            end
        end
    end

    // range select and burnout substitute words
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            range_reg <= '{default: RST_RANGE_SELECT};
            subst_reg <= '{default: RST_FAULT_SUBST};
        end else begin
            for (int c = 0; c < NUM_AI; c++) begin
                if (range_wr[c]) begin
                    range_reg[c] <= req_in.wdata;
                end
                if (subst_hi_wr[c]) begin
                    subst_reg[c][31:16] <= req_in.wdata;
                end
                if (subst_lo_wr[c]) begin
                    subst_reg[c][15:0] <= req_in.wdata;
                end
            end
        end
    end

    // conversion capture and channel condition
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_reg    <= '0;
            scaled_reg <= '0;
            cond_reg   <= '{default: COND_NORMAL};
        end else begin
            for (int c = 0; c < NUM_AI; c++) begin
                if (ai_in[c].valid) begin
                    raw_reg[c]    <= ai_in[c].raw;
                    scaled_reg[c] <= ai_in[c].scaled;
                    if (range_reg[c] == RANGE_4_20MA_BURN &&
                        ai_in[c].burnout) begin
                        cond_reg[c] <= COND_BURNOUT;
                    end else if (ai_in[c].over) begin
                        cond_reg[c] <= COND_OVER;
                    end else if (ai_in[c].under) begin
                        cond_reg[c] <= COND_UNDER;
                    end else begin
                        cond_reg[c] <= COND_NORMAL;
                    end
                end
            end
        end
    end

    // minimum tracking, reset restarts from the last capture
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_min_reg <= '{default: RST_RAW_MIN};
            scl_min_reg <= '{default: RST_SCALED_MIN};
        end else begin
            for (int c = 0; c < NUM_AI; c++) begin
                if (min_rst[c]) begin
                    raw_min_reg[c] <= raw_reg[c];
                    scl_min_reg[c] <= scaled_reg[c];
                end else if (ai_in[c].valid) begin
                    if (ai_in[c].raw < raw_min_reg[c]) begin
                        raw_min_reg[c] <= ai_in[c].raw;
                    end
                    if (ai_in[c].scaled < scl_min_reg[c]) begin
                        scl_min_reg[c] <= ai_in[c].scaled;
                    end
                end
            end
        end
    end

    // maximum tracking
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_max_reg <= '{default: RST_RAW_MAX};
            scl_max_reg <= '{default: RST_SCALED_MAX};
        end else begin
            for (int c = 0; c < NUM_AI; c++) begin
                if (max_rst[c]) begin
                    raw_max_reg[c] <= raw_reg[c];
                    scl_max_reg[c] <= scaled_reg[c];
                end else if (ai_in[c].valid) begin
                    if (ai_in[c].raw > raw_max_reg[c]) begin
                        raw_max_reg[c] <= ai_in[c].raw;
                    end
                    if (ai_in[c].scaled > scl_max_reg[c]) begin
                        scl_max_reg[c] <= ai_in[c].scaled;
                    end
                end
            end
        end
    end

    assign range_mode_out = range_reg;
    assign safe_flag_out  = safe_reg;

endmodule : rimrb_register_bank

// ### include/rimrb_pkg.sv
package rimrb_pkg;

    localparam int NUM_AI   = 4;
    localparam int NUM_DI   = 8;
    localparam int NUM_SAFE = 4;

    // discrete inputs
    localparam logic [15:0] ADDR_INPUT_LEVEL_BITS     = 16'h0000;
    localparam logic [15:0] ADDR_COUNTER_OVERFLOW     = 16'h03e8;
    localparam logic [15:0] ADDR_SAFE_FLAG            = 16'h1010;
    // coils
    localparam logic [15:0] ADDR_COUNTER_RUN_CONTROL  = 16'h0100;
    localparam logic [15:0] ADDR_COUNTER_RESET_COIL   = 16'h0110;
    localparam logic [15:0] ADDR_COUNTER_OVF_CLEAR    = 16'h0120;
    localparam logic [15:0] ADDR_OUTPUT_SAFE_CLEAR    = 16'h1020;
    localparam logic [15:0] ADDR_ANALOG_MIN_RESET     = 16'h1031;
    localparam logic [15:0] ADDR_ANALOG_MAX_RESET     = 16'h1039;
    // holding registers
    localparam logic [15:0] ADDR_ANALOG_RANGE_SELECT  = 16'h0220;
    localparam logic [15:0] ADDR_ANALOG_FAULT_SUBST   = 16'h0230;
    // input registers
    localparam logic [15:0] ADDR_INPUT_COUNTER_VALUE  = 16'h0010;
    localparam logic [15:0] ADDR_PACKED_INPUT_LEVELS  = 16'h0030;
    localparam logic [15:0] ADDR_ANALOG_RAW_VALUE     = 16'h0200;
    localparam logic [15:0] ADDR_ANALOG_SCALED_VALUE  = 16'h0208;
    localparam logic [15:0] ADDR_ANALOG_RAW_MINIMUM   = 16'h0210;
    localparam logic [15:0] ADDR_ANALOG_RAW_MAXIMUM   = 16'h0214;
    localparam logic [15:0] ADDR_ANALOG_SCALED_MIN    = 16'h0218;
    localparam logic [15:0] ADDR_ANALOG_SCALED_MAX    = 16'h0222;
    localparam logic [15:0] ADDR_ANALOG_CONDITION     = 16'h0240;

    // range codes
    localparam logic [15:0] RANGE_0_10V       = 16'h0000;
    localparam logic [15:0] RANGE_4_20MA      = 16'h0001;
    localparam logic [15:0] RANGE_0_20MA      = 16'h0002;
    localparam logic [15:0] RANGE_4_20MA_BURN = 16'h0004;
    // condition codes
    localparam logic [15:0] COND_NORMAL  = 16'h0000;
    localparam logic [15:0] COND_BURNOUT = 16'h0001;
    localparam logic [15:0] COND_OVER    = 16'h0002;
    localparam logic [15:0] COND_UNDER   = 16'h0003;

    // reset values
    localparam logic [15:0] RST_RANGE_SELECT = 16'h0000;
    localparam logic [31:0] RST_FAULT_SUBST  = 32'h0;
    localparam logic [31:0] RST_COUNTER      = 32'h0;
    localparam logic [15:0] RST_RAW_MIN      = 16'hffff;
    localparam logic [15:0] RST_RAW_MAX      = 16'h0000;
    localparam logic [31:0] RST_SCALED_MIN   = 32'hffff_ffff;
    localparam logic [31:0] RST_SCALED_MAX   = 32'h0;

    typedef enum logic [1:0] {
        SPACE_COIL,
        SPACE_DISCRETE,
        SPACE_HOLDING,
        SPACE_INPUT_REG
    } rimrb_space_t;

    typedef struct packed {
        rimrb_space_t space;
        logic         write;
        logic [15:0]  addr;
        logic [15:0]  wdata;
    } rimrb_req_t;

    typedef struct packed {
        logic        err;
        logic [15:0] rdata;
    } rimrb_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        burnout;
        logic        over;
        logic        under;
        logic [15:0] raw;
        logic [31:0] scaled;
    } rimrb_ai_t;

endpackage : rimrb_pkg

// ### testbench/rimrb_register_bank_checker.sv
module rimrb_register_bank_checker
    import rimrb_pkg::*;
(
    // clock and reset
    input wire logic                    sys_clk_in,
    input wire logic                    rst_in,
    // access port
    input wire logic                    req_valid_in,
    input wire rimrb_req_t              req_in,
    input wire logic                    rsp_valid_out,
    input wire rimrb_rsp_t              rsp_out,
    // field side
    input wire logic [NUM_SAFE-1:0]     safe_set_in,
    input wire logic [NUM_AI-1:0][15:0] range_mode_out,
    input wire logic [NUM_SAFE-1:0]     safe_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    logic rng_wr;
    logic clr_wr;
    assign rng_wr = req_valid_in && req_in.write
        && req_in.space == SPACE_HOLDING
        && req_in.addr == ADDR_ANALOG_RANGE_SELECT;
    assign clr_wr = req_valid_in && req_in.write && req_in.wdata[0]
        && req_in.space == SPACE_COIL
        && req_in.addr == ADDR_OUTPUT_SAFE_CLEAR;
    chk_rsp_timing: assert property (req_valid_in |=> rsp_valid_out)
        else $error("no answer");
    chk_rsp_quiet: assert property (!req_valid_in |=> !rsp_valid_out)
        else $error("stray answer");
    chk_range_write: assert property (
        rng_wr && req_in.wdata == RANGE_4_20MA_BURN |=>
        range_mode_out[0] == RANGE_4_20MA_BURN && !rsp_out.err)
        else $error("range not taken");
    chk_range_keep: assert property (
        rng_wr && req_in.wdata == 16'h0003 |=>
        $stable(range_mode_out) && rsp_out.err)
        else $error("bad range kept");
    chk_safe_set: assert property (
        safe_set_in[0] |=> safe_flag_out[0])
        else $error("safe flag not set");
    chk_safe_clear: assert property (
        clr_wr && !safe_set_in[0] |=> !safe_flag_out[0])
        else $error("safe flag not cleared");
    chk_ro_refused: assert property (
        req_valid_in && req_in.write && req_in.space == SPACE_INPUT_REG
        |=> rsp_out.err && rsp_out.rdata == 16'h0000)
        else $error("ro write taken");
    chk_action_zero: assert property (
        req_valid_in && !req_in.write && req_in.space == SPACE_COIL
        && req_in.addr == ADDR_COUNTER_RESET_COIL
        |=> rsp_out.rdata == 16'h0000)
        else $error("coil reads 1");
endmodule : rimrb_register_bank_checker

bind rimrb_register_bank rimrb_register_bank_checker
    rimrb_register_bank_checker_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
    .safe_set_in(safe_set_in), .range_mode_out(range_mode_out),
    .safe_flag_out(safe_flag_out));

// ### testbench/rimrb_client.sv
module rimrb_client
    import rimrb_pkg::*;
(
    // clock
    input  wire logic       sys_clk_in,
    // access port
    output logic            req_valid_out,
    output rimrb_req_t      req_out,
    input  wire logic       rsp_valid_in,
    input  wire rimrb_rsp_t rsp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
    end
    task automatic xfer(input rimrb_space_t sp, input logic wr,
        input logic [15:0] a, input logic [15:0] d,
        output rimrb_rsp_t r);
        @(posedge sys_clk_in);
        req_valid_out <= 1'b1;
        req_out <= '{sp, wr, a, d};
        @(posedge sys_clk_in);
        req_valid_out <= 1'b0;
        // junk on released fields
        req_out <= ~req_out;
        #1;
        r = rsp_valid_in ? rsp_in : 17'h1ffff;
    endtask : xfer
endmodule : rimrb_client

// ### testbench/rimrb_register_bank_tb.sv
module rimrb_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rimrb_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid;
    logic rsp_valid;
    rimrb_req_t req;
    rimrb_rsp_t rsp;
    logic [NUM_DI-1:0] di = '0;
    rimrb_ai_t [NUM_AI-1:0] ai = '0;
    logic [NUM_SAFE-1:0] safe_set = '0;
    logic [NUM_AI-1:0][15:0] rng;
    logic [NUM_SAFE-1:0] sflag;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int unsigned cnt0 = 0;
    logic [31:0] seed = 32'hcc689b0d;
    always #2.5 sys_clk_in = ~sys_clk_in;
    rimrb_register_bank rimrb_register_bank_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .req_valid_in(req_valid), .req_in(req),
        .rsp_valid_out(rsp_valid), .rsp_out(rsp), .di_level_in(di),
        .ai_in(ai), .safe_set_in(safe_set), .range_mode_out(rng),
        .safe_flag_out(sflag));
    rimrb_client rimrb_client_i (.sys_clk_in(sys_clk_in),
        .req_valid_out(req_valid), .req_out(req),
        .rsp_valid_in(rsp_valid), .rsp_in(rsp));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input rimrb_space_t s, input logic [15:0] a,
        output rimrb_rsp_t r);
        rimrb_client_i.xfer(s, 1'b0, a, 16'h0, r);
    endtask : rd
    task automatic wr(input rimrb_space_t s, input logic [15:0] a,
        input logic [15:0] d, output logic e);
        rimrb_rsp_t r;
        rimrb_client_i.xfer(s, 1'b1, a, d, r);
        e = r.err;
    endtask : wr
    task automatic rd32(input rimrb_space_t s, input logic [15:0] a,
        output logic [31:0] w);
        rimrb_rsp_t h;
        rimrb_rsp_t l;
        rd(s, a, h);
        rd(s, a + 16'h1, l);
        w = {h.rdata, l.rdata};
    endtask : rd32
    task automatic samp(input logic [2:0] f, input logic [15:0] raw,
        input logic [31:0] sc);
        @(posedge sys_clk_in);
        ai[1] <= '{1'b1, f[2], f[1], f[0], raw, sc};
        @(posedge sys_clk_in);
        ai[1].valid <= 1'b0;
    endtask : samp
    task automatic pulse(input int n, input bit run);
        repeat (n) begin
            @(posedge sys_clk_in);
            di[0] <= 1'b1;
            @(posedge sys_clk_in);
            di[0] <= 1'b0;
        end
        if (run) cnt0 += n;
    endtask : pulse
    task automatic mm(input logic [15:0] rq[$], input logic [31:0] sq[$]);
        rimrb_rsp_t r;
        logic [31:0] w;
        logic [15:0] a[$];
        logic [15:0] b[$];
        logic [31:0] c[$];
        logic [31:0] d[$];
        a = rq.min();
        b = rq.max();
        c = sq.min();
        d = sq.max();
        rd(SPACE_INPUT_REG, ADDR_ANALOG_RAW_MINIMUM + 16'h1, r);
        check(r, {1'b0, a[0]});
        rd(SPACE_INPUT_REG, ADDR_ANALOG_RAW_MAXIMUM + 16'h1, r);
        check(r, {1'b0, b[0]});
        rd32(SPACE_INPUT_REG, ADDR_ANALOG_SCALED_MIN + 16'h2, w);
        check(w, c[0]);
        rd32(SPACE_INPUT_REG, ADDR_ANALOG_SCALED_MAX + 16'h2, w);
        check(w, d[0]);
    endtask : mm
    initial begin
        rimrb_rsp_t r;
        logic e;
        logic [31:0] w;
        logic [31:0] sub;
        logic [31:0] sc;
        logic [15:0] rq[$];
        logic [31:0] sq[$];
        logic [15:0] codes[4] = '{16'h0, 16'h1, 16'h2, 16'h4};
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (codes[i]) begin
            wr(SPACE_HOLDING, ADDR_ANALOG_RANGE_SELECT, codes[i], e);
            check({e, rng[0]}, {1'b0, codes[i]});
        end
        wr(SPACE_HOLDING, ADDR_ANALOG_RANGE_SELECT, 16'h0003, e);
        check({e, rng[0]}, {1'b1, RANGE_4_20MA_BURN});
        sub = $random(seed);
        wr(SPACE_HOLDING, ADDR_ANALOG_FAULT_SUBST + 16'h2, sub[31:16], e);
        wr(SPACE_HOLDING, ADDR_ANALOG_FAULT_SUBST + 16'h3, sub[15:0], e);
        rd32(SPACE_HOLDING, ADDR_ANALOG_FAULT_SUBST + 16'h2, w);
        check(w, sub);
        repeat (4) begin
            w = $random(seed);
            sc = $random(seed);
            samp(3'b000, w[15:0], sc);
            rq.push_back(w[15:0]);
            sq.push_back(sc);
            rd(SPACE_INPUT_REG, ADDR_ANALOG_RAW_VALUE + 16'h1, r);
            check(r, {1'b0, w[15:0]});
            rd32(SPACE_INPUT_REG, ADDR_ANALOG_SCALED_VALUE + 16'h2, w);
            check(w, sc);
            mm(rq, sq);
        end
        wr(SPACE_COIL, ADDR_ANALOG_MIN_RESET + 16'h1, 16'h0001, e);
        wr(SPACE_COIL, ADDR_ANALOG_MAX_RESET + 16'h1, 16'h0001, e);
        rq = '{rq[$]};
        sq = '{sq[$]};
        mm(rq, sq);
        wr(SPACE_HOLDING, ADDR_ANALOG_RANGE_SELECT + 16'h1, 16'h0004, e);
        for (int k = 0; k < 4; k++) begin
            samp(3'(3'b100 >> k), 16'h1234, 32'h0);
            rd(SPACE_INPUT_REG, ADDR_ANALOG_CONDITION + 16'h1, r);
            check(r.rdata, (k + 1) % 4);
            rd32(SPACE_INPUT_REG, ADDR_ANALOG_SCALED_VALUE + 16'h2, w);
            check(w, k == 0 ? sub : 32'h0);
        end
        w = $random(seed);
        @(posedge sys_clk_in);
        di <= w[7:0];
        repeat (3) @(posedge sys_clk_in);
        rd(SPACE_INPUT_REG, ADDR_PACKED_INPUT_LEVELS, r);
        check(r.rdata, {8'h00, w[7:0]});
        for (int k = 0; k < NUM_DI; k++) begin
            rd(SPACE_DISCRETE, ADDR_INPUT_LEVEL_BITS + 16'(k), r);
            check(r, {16'h0, w[k]});
        end
        @(posedge sys_clk_in);
        di <= '0;
        wr(SPACE_COIL, ADDR_COUNTER_RUN_CONTROL, 16'h0001, e);
        pulse(3, 1'b1);
        rd(SPACE_COIL, ADDR_COUNTER_RUN_CONTROL, r);
        check(r.rdata, 16'h0001);
        rd32(SPACE_INPUT_REG, ADDR_INPUT_COUNTER_VALUE, w);
        check(w, cnt0);
        wr(SPACE_COIL, ADDR_COUNTER_RUN_CONTROL, 16'h0000, e);
        pulse(2, 1'b0);
        rd32(SPACE_INPUT_REG, ADDR_INPUT_COUNTER_VALUE, w);
        check(w, cnt0);
        wr(SPACE_COIL, ADDR_COUNTER_RESET_COIL, 16'h0001, e);
        cnt0 = 0;
        rd32(SPACE_INPUT_REG, ADDR_INPUT_COUNTER_VALUE, w);
        check(w, cnt0);
        rd(SPACE_COIL, ADDR_COUNTER_RESET_COIL, r);
        check(r, 32'h0);
        wr(SPACE_COIL, ADDR_COUNTER_OVF_CLEAR, 16'h0001, e);
        check(e, 1'b0);
        rd(SPACE_DISCRETE, ADDR_COUNTER_OVERFLOW, r);
        check(r, 32'h0);
        @(posedge sys_clk_in);
        safe_set <= 4'h1;
        @(posedge sys_clk_in);
        safe_set <= 4'h0;
        rd(SPACE_DISCRETE, ADDR_SAFE_FLAG, r);
        check(r, 32'h1);
        wr(SPACE_COIL, ADDR_OUTPUT_SAFE_CLEAR, 16'h0001, e);
        rd(SPACE_DISCRETE, ADDR_SAFE_FLAG, r);
        check(r, 32'h0);
        wr(SPACE_INPUT_REG, ADDR_ANALOG_RAW_VALUE, 16'h0001, e);
        check(e, 1'b1);
        rd(SPACE_HOLDING, 16'h0300, r);
        check(r, {1'b1, 16'h0});
        end_of_test();
    end
endmodule : rimrb_register_bank_tb
